// File: logic/mbtc_top.sv
// Purpose: Masked BCD time comparator with word and double-word compare.
// Assumes: The sequencer drives operands on the same clock as MCLK_I.
// Notes: One operation per OP_VALID_I pulse, results registered one edge later.
// Contract
// - Control bits 0..5 mask sec..year fields
// - Error flag set only when all masked
// - Compare unmasked fields, condition on relation
// - Time compare also updates six flags
// - Flags follow equal, greater, less table
// - Result connects as load, and, or
// - Sec..month compared as 8-bit values, year as 9-bit key
// - Three calendar words, low/high byte fields
// - Calendar fields are BCD within ranges
// - Clockless variant reads 01-01-01 01:01:01
// - Word compare unsigned, writes flags only
// - Double compare 32-bit unsigned, flags only
// - All masked: no execution, condition off
// - Years 98,99 precede 00..97
`timescale 1ns/1ps
`default_nettype none
module mbtc_top
  import mbtc_pkg::*;
#(
  parameter bit HAS_CLOCK = 1'b1
)(
  // Clock and reset.
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Operation request from the sequencer.
  input wire logic OP_VALID_I,
  input wire logic [3:0] OP_CODE_I,
  input wire logic [1:0] CONNECT_I,
  input wire logic RUNG_I,
  input wire logic USE_CLOCK_I,
  input wire logic [WORD_W-1:0] CTRL_WORD_I,
  // Operand words; word compare uses word 0, double compare uses words 0 and 1.
  input wire logic [WORD_W-1:0] S1_WORD0_I,
  input wire logic [WORD_W-1:0] S1_WORD1_I,
  input wire logic [WORD_W-1:0] S1_WORD2_I,
  input wire logic [WORD_W-1:0] S2_WORD0_I,
  input wire logic [WORD_W-1:0] S2_WORD1_I,
  input wire logic [WORD_W-1:0] S2_WORD2_I,
  // Calendar load port.
  input wire logic CAL_WR_I,
  input wire logic [1:0] CAL_SEL_I,
  input wire logic [WORD_W-1:0] CAL_DATA_I,
  // Calendar words.
  output logic [WORD_W-1:0] CLOCK_SECONDS_MINUTES_O,
  output logic [WORD_W-1:0] CLOCK_HOURS_DAY_O,
  output logic [WORD_W-1:0] CLOCK_MONTH_YEAR_O,
  // Results.
  output logic DONE_O,
  output logic EXEC_COND_O,
  output logic ERROR_FLAG_O,
  output logic EQUAL_FLAG_O,
  output logic NOT_EQUAL_FLAG_O,
  output logic LESS_FLAG_O,
  output logic LESS_EQUAL_FLAG_O,
  output logic GREATER_FLAG_O,
  output logic GREATER_EQUAL_FLAG_O
);
  logic [WORD_W-1:0] cal_reg [3];
  logic [WORD_W-1:0] cal_w0, cal_w1, cal_w2;
  logic [WORD_W-1:0] a_w0, a_w1, a_w2;
  logic [NUM_FIELDS-1:0] mask;
  logic all_masked, time_gt, time_lt, time_op;
  logic word_gt, word_lt, dbl_gt, dbl_lt, res_gt, res_lt, res_eq;
  logic relation, cond;
  logic done_reg, exec_reg, err_reg;
  logic [5:0] flags_reg, flags_next;

  assign mask = CTRL_WORD_I[MASK_LSB +: NUM_FIELDS];
  assign all_masked = (mask == MASK_ALL);
  assign time_op = (OP_CODE_I <= 4'(MBTC_TIME_GREATER_EQUAL_OP));

  // Writes that break the BCD ranges are dropped so the area stays valid.
  function automatic logic cal_word_ok(input logic [1:0] sel, input logic [15:0] d);
    case (sel)
      CAL_SEL_SEC_MIN: cal_word_ok = mbtc_bcd_ok(d[7:0], 8'h00, 8'h59) && mbtc_bcd_ok(d[15:8], 8'h00, 8'h59);
      CAL_SEL_HOUR_DAY: cal_word_ok = mbtc_bcd_ok(d[7:0], 8'h00, 8'h23) && mbtc_bcd_ok(d[15:8], 8'h01, 8'h31);
      CAL_SEL_MONTH_YEAR: cal_word_ok = mbtc_bcd_ok(d[7:0], 8'h01, 8'h12) && mbtc_bcd_ok(d[15:8], 8'h00, 8'h99);
      default: cal_word_ok = 1'b0;
    endcase
  endfunction

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cal_reg[0] <= CAL_RESET_WORD;
      cal_reg[1] <= CAL_RESET_WORD;
      cal_reg[2] <= CAL_RESET_WORD;
    end else if (HAS_CLOCK && CAL_WR_I && cal_word_ok(CAL_SEL_I, CAL_DATA_I)) begin
      cal_reg[CAL_SEL_I] <= CAL_DATA_I;
    end
  end

  // Without a clock the area is frozen at its fixed pattern.
  assign cal_w0 = HAS_CLOCK ? cal_reg[0] : CAL_FIXED_WORD;
  assign cal_w1 = HAS_CLOCK ? cal_reg[1] : CAL_FIXED_WORD;
  assign cal_w2 = HAS_CLOCK ? cal_reg[2] : CAL_FIXED_WORD;
  assign CLOCK_SECONDS_MINUTES_O = cal_w0;
  assign CLOCK_HOURS_DAY_O = cal_w1;
  assign CLOCK_MONTH_YEAR_O = cal_w2;

  // The present time may come straight from the calendar words.
  assign a_w0 = USE_CLOCK_I ? cal_w0 : S1_WORD0_I;
  assign a_w1 = USE_CLOCK_I ? cal_w1 : S1_WORD1_I;
  assign a_w2 = USE_CLOCK_I ? cal_w2 : S1_WORD2_I;

  mbtc_field_cmp u_field_cmp (
    .a_w0_i(a_w0),
    .a_w1_i(a_w1),
    .a_w2_i(a_w2),
    .b_w0_i(S2_WORD0_I),
    .b_w1_i(S2_WORD1_I),
    .b_w2_i(S2_WORD2_I),
    .mask_i(mask),
    .gt_o(time_gt),
    .lt_o(time_lt)
  );

  assign word_gt = (S1_WORD0_I > S2_WORD0_I);
  assign word_lt = (S1_WORD0_I < S2_WORD0_I);
  assign dbl_gt = ({S1_WORD1_I, S1_WORD0_I} > {S2_WORD1_I, S2_WORD0_I});
  assign dbl_lt = ({S1_WORD1_I, S1_WORD0_I} < {S2_WORD1_I, S2_WORD0_I});

  always_comb begin
    case (OP_CODE_I)
      MBTC_WORD_COMPARE_OP: begin
        res_gt = word_gt;
        res_lt = word_lt;
      end
      MBTC_DOUBLE_WORD_COMPARE_OP: begin
        res_gt = dbl_gt;
        res_lt = dbl_lt;
      end
      default: begin
        res_gt = time_gt;
        res_lt = time_lt;
      end
    endcase
  end
  assign res_eq = !res_gt && !res_lt;

  // Flag order: eq, ne, lt, le, gt, ge.
  assign flags_next = {res_gt | res_eq, res_gt, res_lt | res_eq, res_lt, !res_eq, res_eq};

  always_comb begin
    case (OP_CODE_I)
      MBTC_TIME_EQUAL_OP: relation = flags_next[0];
      MBTC_TIME_NOT_EQUAL_OP: relation = flags_next[1];
      MBTC_TIME_LESS_OP: relation = flags_next[2];
      MBTC_TIME_LESS_EQUAL_OP: relation = flags_next[3];
      MBTC_TIME_GREATER_OP: relation = flags_next[4];
      MBTC_TIME_GREATER_EQUAL_OP: relation = flags_next[5];
      default: relation = 1'b0;
    endcase
  end

  // A contact joins the incoming rung state; the rung is later closed by
  // another element, so the condition itself is never a coil.
  always_comb begin
    case (CONNECT_I)
      MBTC_CONN_AND: cond = RUNG_I && relation;
      MBTC_CONN_OR: cond = RUNG_I || relation;
      default: cond = relation;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= OP_VALID_I;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      exec_reg <= 1'b0;
    end else if (OP_VALID_I && time_op) begin
      exec_reg <= all_masked ? 1'b0 : cond;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      err_reg <= 1'b0;
    end else if (OP_VALID_I && time_op) begin
      err_reg <= all_masked;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_reg <= 6'h00;
    end else if (OP_VALID_I && !(time_op && all_masked)) begin
      flags_reg <= flags_next;
    end
  end

  assign DONE_O = done_reg;
  assign EXEC_COND_O = exec_reg;
  assign ERROR_FLAG_O = err_reg;
  assign EQUAL_FLAG_O = flags_reg[0];
  assign NOT_EQUAL_FLAG_O = flags_reg[1];
  assign LESS_FLAG_O = flags_reg[2];
  assign LESS_EQUAL_FLAG_O = flags_reg[3];
  assign GREATER_FLAG_O = flags_reg[4];
  assign GREATER_EQUAL_FLAG_O = flags_reg[5];

  property p_err_all_masked;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && time_op) |=> (ERROR_FLAG_O == $past(all_masked));
  endproperty
  a_err_all_masked: assert property (p_err_all_masked) else $error("error flag wrong after time op");

  property p_masked_off;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && time_op && all_masked) |=> !EXEC_COND_O && $stable(flags_reg);
  endproperty
  a_masked_off: assert property (p_masked_off) else $error("all-masked op executed");

  // Flags are all zero from reset until the first executed compare, even past an all-masked op.
  property p_flag_pairs;
    @(posedge MCLK_I) disable iff (RST_I)
    (flags_reg != 6'h00) |-> (EQUAL_FLAG_O != NOT_EQUAL_FLAG_O)
      && (GREATER_EQUAL_FLAG_O == (GREATER_FLAG_O || EQUAL_FLAG_O))
      && (LESS_EQUAL_FLAG_O == (LESS_FLAG_O || EQUAL_FLAG_O)) && !(LESS_FLAG_O && GREATER_FLAG_O);
  endproperty
  a_flag_pairs: assert property (p_flag_pairs) else $error("relation flags inconsistent");

  property p_word_cmp;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && OP_CODE_I == 4'(MBTC_WORD_COMPARE_OP)) |=>
      (GREATER_FLAG_O == ($past(S1_WORD0_I) > $past(S2_WORD0_I))) && $stable(ERROR_FLAG_O) && $stable(EXEC_COND_O);
  endproperty
  a_word_cmp: assert property (p_word_cmp) else $error("word compare result wrong");

  property p_dbl_cmp;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && OP_CODE_I == 4'(MBTC_DOUBLE_WORD_COMPARE_OP)) |=>
      (LESS_FLAG_O == ({$past(S1_WORD1_I), $past(S1_WORD0_I)} < {$past(S2_WORD1_I), $past(S2_WORD0_I)}))
      && $stable(ERROR_FLAG_O);
  endproperty
  a_dbl_cmp: assert property (p_dbl_cmp) else $error("double compare result wrong");

  property p_and_gate;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && time_op && CONNECT_I == 2'(MBTC_CONN_AND) && !RUNG_I) |=> !EXEC_COND_O;
  endproperty
  a_and_gate: assert property (p_and_gate) else $error("and contact passed with rung off");

  property p_or_gate;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && time_op && !all_masked && CONNECT_I == 2'(MBTC_CONN_OR) && RUNG_I) |=> EXEC_COND_O;
  endproperty
  a_or_gate: assert property (p_or_gate) else $error("or contact blocked with rung on");

  property p_exec_eq;
    @(posedge MCLK_I) disable iff (RST_I)
    (OP_VALID_I && OP_CODE_I == 4'(MBTC_TIME_EQUAL_OP) && !all_masked && CONNECT_I == 2'(MBTC_CONN_LOAD))
      |=> (EXEC_COND_O == EQUAL_FLAG_O) ##1 $stable(EXEC_COND_O) || $past(OP_VALID_I);
  endproperty
  a_exec_eq: assert property (p_exec_eq) else $error("condition disagrees with equal flag");

  property p_fixed_cal;
    @(posedge MCLK_I) disable iff (RST_I)
    !HAS_CLOCK |-> (CLOCK_SECONDS_MINUTES_O == CAL_FIXED_WORD) && (CLOCK_HOURS_DAY_O == CAL_FIXED_WORD)
      && (CLOCK_MONTH_YEAR_O == CAL_FIXED_WORD);
  endproperty
  a_fixed_cal: assert property (p_fixed_cal) else $error("clockless calendar not fixed");
endmodule
`default_nettype wire

// File: logic/mbtc_pkg.sv
// Purpose: Shared constants and types for the masked BCD time comparator.
// Assumes: Words are 16 bits and time fields are 8-bit BCD bytes.
// Notes: Opcodes are local encodings of the operation port.
package mbtc_pkg;
  localparam int WORD_W = 16;
  localparam int FIELD_W = 8;
  localparam int NUM_FIELDS = 6;
  localparam int MASK_LSB = 0;
  localparam logic [5:0] MASK_ALL = 6'h3F;
  localparam logic [7:0] YEAR_WRAP = 8'h98;
  localparam logic [15:0] CAL_RESET_WORD = 16'h0101;
  localparam logic [15:0] CAL_FIXED_WORD = 16'h0101;
  localparam logic [1:0] CAL_SEL_SEC_MIN = 2'h0;
  localparam logic [1:0] CAL_SEL_HOUR_DAY = 2'h1;
  localparam logic [1:0] CAL_SEL_MONTH_YEAR = 2'h2;

  typedef enum logic [3:0] {
    MBTC_TIME_EQUAL_OP = 4'h0,
    MBTC_TIME_NOT_EQUAL_OP = 4'h1,
    MBTC_TIME_LESS_OP = 4'h2,
    MBTC_TIME_LESS_EQUAL_OP = 4'h3,
    MBTC_TIME_GREATER_OP = 4'h4,
    MBTC_TIME_GREATER_EQUAL_OP = 4'h5,
    MBTC_WORD_COMPARE_OP = 4'h6,
    MBTC_DOUBLE_WORD_COMPARE_OP = 4'h7
  } mbtc_op_e;

  typedef enum logic [1:0] {
    MBTC_CONN_LOAD = 2'h0,
    MBTC_CONN_AND = 2'h1,
    MBTC_CONN_OR = 2'h2
  } mbtc_conn_e;

  function automatic logic mbtc_bcd_ok(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    mbtc_bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction
endpackage

// File: logic/mbtc_field_cmp.sv
// Purpose: Masked significance-ordered compare of two three-word BCD times.
// Assumes: Inputs are held stable by the caller for the sampling edge.
// Notes: Purely combinational; the parent registers the outcome.
`timescale 1ns/1ps
`default_nettype none
module mbtc_field_cmp
  import mbtc_pkg::*;
(
  // Operands, three words each.
  input wire logic [WORD_W-1:0] a_w0_i,
  input wire logic [WORD_W-1:0] a_w1_i,
  input wire logic [WORD_W-1:0] a_w2_i,
  input wire logic [WORD_W-1:0] b_w0_i,
  input wire logic [WORD_W-1:0] b_w1_i,
  input wire logic [WORD_W-1:0] b_w2_i,
  // Field mask, bit set removes the field.
  input wire logic [NUM_FIELDS-1:0] mask_i,
  // Outcome.
  output logic gt_o,
  output logic lt_o
);
  logic [8:0] a_key [NUM_FIELDS];
  logic [8:0] b_key [NUM_FIELDS];

  // Years 98 and 99 belong to the previous century, so they sort below 00.
  function automatic logic [8:0] year_key(input logic [7:0] y);
    year_key = {(y < YEAR_WRAP), y};
  endfunction

  always_comb begin
    // Field index: 0 sec, 1 min, 2 hour, 3 day, 4 month, 5 year.
    a_key[0] = {1'b0, a_w0_i[7:0]};
    a_key[1] = {1'b0, a_w0_i[15:8]};
    a_key[2] = {1'b0, a_w1_i[7:0]};
    a_key[3] = {1'b0, a_w1_i[15:8]};
    a_key[4] = {1'b0, a_w2_i[7:0]};
    a_key[5] = year_key(a_w2_i[15:8]);
    b_key[0] = {1'b0, b_w0_i[7:0]};
    b_key[1] = {1'b0, b_w0_i[15:8]};
    b_key[2] = {1'b0, b_w1_i[7:0]};
    b_key[3] = {1'b0, b_w1_i[15:8]};
    b_key[4] = {1'b0, b_w2_i[7:0]};
    b_key[5] = year_key(b_w2_i[15:8]);
  end

  // Walk from seconds up so the most significant unequal field overwrites.
  always_comb begin
    gt_o = 1'b0;
    lt_o = 1'b0;
    for (int i = 0; i < NUM_FIELDS; i++) begin
      if (!mask_i[i] && (a_key[i] != b_key[i])) begin
        gt_o = (a_key[i] > b_key[i]);
        lt_o = (a_key[i] < b_key[i]);
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/mbtc_cal_loader.sv
// Purpose: Stand-in for the party that loads the calendar words.
// Assumes: Shares the bench clock; one whole word per write strobe.
// Notes: Between writes the lines show a neutral select and inverted data.
`timescale 1ns/1ps
`default_nettype none
module mbtc_cal_loader
  import mbtc_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Calendar load lines.
  output logic wr_o = 1'b0,
  output logic [1:0] sel_o = 2'h3,
  output logic [WORD_W-1:0] data_o = 16'hFFFF
);
  // Each write carries a full word of one group, never a lone byte.
  task automatic load(input logic [1:0] sel, input logic [15:0] data);
    @(posedge clk_i);
    wr_o <= 1'b1;
    sel_o <= sel;
    data_o <= data;
    @(posedge clk_i);
    wr_o <= 1'b0;
    sel_o <= 2'h3;
    data_o <= ~data;
  endtask
endmodule
`default_nettype wire

// File: tb/mbtc_top_tb_top.sv
// Purpose: Self-checking bench for the masked BCD time comparator.
// Assumes: One request at a time, results read just after the taking edge.
// Notes: Expected flags persist between calls, so unchanged flags are checked.
`timescale 1ns/1ps
`default_nettype none
module mbtc_top_tb_top
  import mbtc_pkg::*;
;
  localparam logic [47:0] t_lo = 48'h2412_1513_3044;
  localparam logic [47:0] t_mid = 48'h2412_1513_3045;
  localparam logic [47:0] t_hi = 48'h2512_1513_3044;
  logic clk, rst = 1'b1, ov = 1'b0, rg = 1'b0, uc = 1'b0;
  logic [3:0] op = 4'h0;
  logic [1:0] cn = 2'h0;
  logic [15:0] c = 16'h0000;
  logic [47:0] a = 48'h0, b = 48'h0, cal = 48'h0101_0101_0101;
  logic [5:0] ef = 6'h00;
  logic ex = 1'b0, ee = 1'b0;
  int failures = 0;
  int checked = 0;
  wire logic [15:0] w0, w1, w2, cdat;
  wire logic [1:0] csel;
  wire logic cwr, dn, xo, eo, f_eq, f_ne, f_lt, f_le, f_gt, f_ge;
  wire logic [5:0] fl = {f_eq, f_ne, f_lt, f_le, f_gt, f_ge};
  wire logic [15:0] fw0, fw1, fw2;
  wire logic fx_eq;

  mbtc_top dut_u (
    .MCLK_I(clk), .RST_I(rst), .OP_VALID_I(ov), .OP_CODE_I(op), .CONNECT_I(cn), .RUNG_I(rg),
    .USE_CLOCK_I(uc), .CTRL_WORD_I(c), .S1_WORD0_I(a[15:0]), .S1_WORD1_I(a[31:16]), .S1_WORD2_I(a[47:32]),
    .S2_WORD0_I(b[15:0]), .S2_WORD1_I(b[31:16]), .S2_WORD2_I(b[47:32]), .CAL_WR_I(cwr), .CAL_SEL_I(csel),
    .CAL_DATA_I(cdat), .CLOCK_SECONDS_MINUTES_O(w0), .CLOCK_HOURS_DAY_O(w1), .CLOCK_MONTH_YEAR_O(w2),
    .DONE_O(dn), .EXEC_COND_O(xo), .ERROR_FLAG_O(eo), .EQUAL_FLAG_O(f_eq), .NOT_EQUAL_FLAG_O(f_ne),
    .LESS_FLAG_O(f_lt), .LESS_EQUAL_FLAG_O(f_le), .GREATER_FLAG_O(f_gt), .GREATER_EQUAL_FLAG_O(f_ge)
  );
  mbtc_cal_loader cl_u (.clk_i(clk), .wr_o(cwr), .sel_o(csel), .data_o(cdat));
  // A clockless copy shares every input; its calendar words must never move.
  mbtc_top #(.HAS_CLOCK(1'b0)) fixed_u (
    .MCLK_I(clk), .RST_I(rst), .OP_VALID_I(ov), .OP_CODE_I(op), .CONNECT_I(cn), .RUNG_I(rg),
    .USE_CLOCK_I(uc), .CTRL_WORD_I(c), .S1_WORD0_I(a[15:0]), .S1_WORD1_I(a[31:16]), .S1_WORD2_I(a[47:32]),
    .S2_WORD0_I(b[15:0]), .S2_WORD1_I(b[31:16]), .S2_WORD2_I(b[47:32]), .CAL_WR_I(cwr), .CAL_SEL_I(csel),
    .CAL_DATA_I(cdat), .CLOCK_SECONDS_MINUTES_O(fw0), .CLOCK_HOURS_DAY_O(fw1), .CLOCK_MONTH_YEAR_O(fw2),
    .DONE_O(), .EXEC_COND_O(), .ERROR_FLAG_O(), .EQUAL_FLAG_O(fx_eq), .NOT_EQUAL_FLAG_O(),
    .LESS_FLAG_O(), .LESS_EQUAL_FLAG_O(), .GREATER_FLAG_O(), .GREATER_EQUAL_FLAG_O()
  );

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [5:0] flg(input logic gt, input logic lt);
    flg = {~gt & ~lt, gt | lt, lt, ~gt, gt, ~lt};
  endfunction

  // Years 98 and 99 get a low top bit so they sort below 00 to 97.
  function automatic logic [48:0] tkey(input logic [47:0] t, input logic [5:0] m);
    tkey = {{t[47:40] < 8'h98, t[47:40]} & {9{~m[5]}}, t[39:32] & {8{~m[4]}}, t[31:24] & {8{~m[3]}},
            t[23:16] & {8{~m[2]}}, t[15:8] & {8{~m[1]}}, t[7:0] & {8{~m[0]}}};
  endfunction

  task automatic run(input logic [3:0] o, input logic [1:0] n, input logic r, input logic u,
                     input logic [15:0] m, input logic [47:0] sa, input logic [47:0] sb);
    logic [47:0] p;
    p = u ? cal : sa;
    @(posedge clk);
    ov <= 1'b1;
    op <= o;
    cn <= n;
    rg <= r;
    uc <= u;
    c <= m;
    a <= sa;
    b <= sb;
    @(posedge clk);
    ov <= 1'b0;
    #1;
    if (o == 4'h6) begin
      ef = flg(sa[15:0] > sb[15:0], sa[15:0] < sb[15:0]);
    end else if (o == 4'h7) begin
      ef = flg(sa[31:0] > sb[31:0], sa[31:0] < sb[31:0]);
    end else if (m[5:0] == MASK_ALL) begin
      ee = 1'b1;
      ex = 1'b0;
    end else begin
      ef = flg(tkey(p, m[5:0]) > tkey(sb, m[5:0]), tkey(p, m[5:0]) < tkey(sb, m[5:0]));
      ee = 1'b0;
      ex = (n == 2'h1) ? (r & ef[5 - o]) : (n == 2'h2) ? (r | ef[5 - o]) : ef[5 - o];
    end
    chk("done", 16'h0001, 16'(dn));
    chk("flags", 16'(ef), 16'(fl));
    chk("exec", 16'(ex), 16'(xo));
    chk("error", 16'(ee), 16'(eo));
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("cal0", 16'h0101, w0);
    chk("cal1", 16'h0101, w1);
    chk("cal2", 16'h0101, w2);
    chk("flags", 16'h0000, 16'(fl));
    chk("done", 16'h0000, 16'(dn));
    chk("exec", 16'h0000, 16'(xo));
    chk("error", 16'h0000, 16'(eo));
    chk("fixed1", 16'h0101, fw1);
    $display("test reset done");
    // Every relation in every connection form, against less, equal and greater times.
    for (int k = 0; k < 54; k++) begin
      run(4'(k / 9), 2'((k / 3) % 3), 1'(k % 2), 1'b0, 16'h0000,
          (k % 3 == 0) ? t_lo : (k % 3 == 1) ? t_mid : t_hi, t_mid);
    end
    $display("test relations done");
    run(4'h0, 2'h0, 1'b0, 1'b0, 16'h0039, t_mid, 48'h9901_0113_3000);
    run(4'h4, 2'h0, 1'b0, 1'b0, 16'h003E, t_mid, t_lo);
    run(4'h2, 2'h1, 1'b1, 1'b0, 16'h0000, 48'h9812_1513_3045, 48'h0012_1513_3045);
    run(4'h2, 2'h2, 1'b0, 1'b0, 16'h001F, 48'h9901_0101_0101, 48'h9701_0101_0101);
    run(4'h4, 2'h3, 1'b0, 1'b0, 16'h0000, t_hi, t_mid);
    run(4'h5, 2'h0, 1'b0, 1'b0, 16'h003F, t_lo, t_mid);
    $display("test masks done");
    run(4'h6, 2'h0, 1'b0, 1'b0, 16'h003F, 48'h0000_0000_8000, 48'h0000_0000_0001);
    run(4'h6, 2'h0, 1'b0, 1'b0, 16'h0000, 48'h0000_FFFF_0005, 48'h0000_0000_0005);
    run(4'h7, 2'h0, 1'b0, 1'b0, 16'h0000, 48'h0000_0001_0000, 48'h0000_0000_FFFF);
    run(4'h7, 2'h0, 1'b0, 1'b0, 16'h0000, 48'hFFFF_0000_FFFF, 48'h0000_0001_0000);
    run(4'h5, 2'h0, 1'b0, 1'b0, 16'hFFC0, t_mid, t_mid);
    $display("test compares done");
    cl_u.load(CAL_SEL_MONTH_YEAR, 16'h2412);
    cl_u.load(CAL_SEL_HOUR_DAY, 16'h3123);
    cl_u.load(CAL_SEL_SEC_MIN, 16'h0060);
    cl_u.load(CAL_SEL_HOUR_DAY, 16'h0023);
    cl_u.load(2'h3, 16'h1111);
    #1;
    cal = 48'h2412_3123_0101;
    chk("cal0", cal[15:0], w0);
    chk("cal1", cal[31:16], w1);
    chk("cal2", cal[47:32], w2);
    chk("fixed0", 16'h0101, fw0);
    chk("fixed1", 16'h0101, fw1);
    chk("fixed2", 16'h0101, fw2);
    run(4'h1, 2'h0, 1'b0, 1'b1, 16'h0000, 48'h0, 48'h2412_3123_0101);
    run(4'h3, 2'h2, 1'b0, 1'b1, 16'h0000, 48'h0, 48'h2412_3123_0100);
    run(4'h0, 2'h0, 1'b0, 1'b1, 16'h0000, 48'h0, 48'h0101_0101_0101);
    chk("fixed_eq", 16'h0001, 16'(fx_eq));
    $display("test calendar done");
    complete_run();
  end
endmodule
`default_nettype wire
